// >>> rtl/cwl_pkg.sv
// package for the configuration word loader: flash addresses, field positions, encodings
// assumes a 24-bit wide flash read port addressed in program-word units
package cwl_pkg;

  localparam logic [23:0] CWL_CFG_SPACE_LO = 24'h800000;
  localparam logic [23:0] CWL_CFG_SPACE_HI = 24'hFFFFFF;
  localparam logic [23:0] CWL_CFG_MAP_BASE = 24'hF80000;

  localparam logic [23:0] CWL_LARGE_WORD_ONE = 24'h00ABFE;
  localparam logic [23:0] CWL_LARGE_WORD_TWO = 24'h00ABFC;
  localparam logic [23:0] CWL_SMALL_WORD_ONE = 24'h0057FE;
  localparam logic [23:0] CWL_SMALL_WORD_TWO = 24'h0057FC;
  localparam logic [23:0] CWL_LARGE_LAST_PAGE = 24'h00AC00;
  localparam logic [23:0] CWL_SMALL_LAST_PAGE = 24'h005800;
  localparam logic [23:0] CWL_PAGE_SIZE = 24'h000400;

  // value of an unprogrammed word; upper byte always reads ones
  localparam logic [23:0] CWL_WORD_RESET = 24'hFFFFFF;
  localparam logic [23:0] CWL_WORD_ONE_IMPL = 24'h007BDF;
  localparam logic [23:0] CWL_WORD_TWO_IMPL = 24'h0087F7;

  localparam int CWL_W1_SCAN = 14;
  localparam int CWL_W1_GCP = 13;
  localparam int CWL_W1_WRP = 12;
  localparam int CWL_W1_DBG = 11;
  localparam int CWL_W1_ICS = 8;
  localparam int CWL_W1_WDTEN = 7;
  localparam int CWL_W1_WIN = 6;
  localparam int CWL_W1_PSA = 4;
  localparam int CWL_W1_PS = 0;
  localparam int CWL_W2_TWO_SPEED_STARTUP_ON = 15;
  localparam int CWL_W2_OSC = 8;
  localparam int CWL_W2_CKSM = 6;
  localparam int CWL_W2_OSCIO = 5;
  localparam int CWL_W2_IOL1 = 4;
  localparam int CWL_W2_I2C = 2;
  localparam int CWL_W2_POSC = 0;

  localparam logic [1:0] CWL_ICS_RESERVED = 2'h0;
  localparam logic [2:0] CWL_OSC_RESERVED = 3'h6;
  localparam logic [1:0] CWL_POSC_OFF = 2'h3;
  localparam logic [1:0] CWL_POSC_EC = 2'h0;
  localparam logic [7:0] CWL_PRE_HIGH = 8'h80;
  localparam logic [7:0] CWL_PRE_LOW = 8'h20;

  typedef enum logic [2:0] {
    CWL_IDLE = 3'h0,
    CWL_RD_ONE = 3'h1,
    CWL_WT_ONE = 3'h2,
    CWL_RD_TWO = 3'h3,
    CWL_WT_TWO = 3'h4,
    CWL_DONE = 3'h5
  } cwl_state_t;

endpackage

// >>> rtl/cwl_config_word_loader.sv
// configuration word loader: copies two flash words into volatile registers at every reset
// assumes a flash read port with one-cycle-or-more latency and a table access port
//
// Operation
// - programmed bit reads 0, unprogrammed bit reads 1.
// - config bits mapped from F80000h; space 800000h-FFFFFFh reached by table access only.
// - registers are volatile; reloaded from flash on every reset.
// - words fetched from top of flash: ABFEh/ABFCh large, 57FEh/57FCh small.
// - erasing last flash page clears the words, enabling code protection.
// - bit 14 of word one enables scan port; changeable only via serial programming.
// - bit 13 of word one at 0 protects all program memory.
// - bit 12 of word one at 0 blocks all program memory writes.
// - bit 11 of word one: 1 operational mode, 0 debug mode at reset.
// - bits 9-8 of word one route emulator pins; 00 reserved.
// - bit 7 of word one enables the watchdog.
// - bit 6 of word one: 1 standard, 0 windowed watchdog needing enable.
// - bit 4 of word one: prescaler 1:128 when 1, 1:32 when 0.
// - bits 3-0 of word one: postscaler is two to the field value.
// - bit 15 of word two enables two-speed start-up.
// - bits 10-8 of word two select oscillator after reset; 110 reserved.
// - bits 7-6 of word two: 1x none, 01 switching, 00 switching and monitor.
// - bit 5 of word two drives clock out only when primary mode is 11 or 00.
// - bit 4 of word two makes pin-select lock one-shot after unlock.
// - bit 2 of word two: 1 default I2C pins, 0 alternate pins.
// - bits 1-0 of word two set primary oscillator mode.
`timescale 1ns/1ps
module cwl_config_word_loader #(
  parameter bit LARGE_MEMORY = 1'b1
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CLK_EN,
  // flash read port used by the loader
  output logic FLASH_RD,
  output logic [23:0] FLASH_ADDR,
  input wire logic FLASH_VALID,
  input wire logic [23:0] FLASH_DATA,
  // flash maintenance notice: page erase events
  input wire logic FLASH_ERASE,
  input wire logic [23:0] FLASH_ERASE_ADDR,
  // table access port into configuration space
  input wire logic TBL_RD,
  input wire logic TBL_WR,
  input wire logic [23:0] TBL_ADDR,
  input wire logic [23:0] TBL_WDATA,
  input wire logic TBL_SERIAL_PROG,
  output logic [23:0] TBL_RDATA,
  output logic TBL_ACK,
  output logic TBL_ERR,
  // pin-select lock request and state
  input wire logic PIN_UNLOCKED,
  input wire logic PIN_LOCK_SET,
  input wire logic PIN_LOCK_CLR,
  output logic PIN_SELECT_LOCK,
  output logic PIN_SELECT_WR_OK,
  // load status and decoded configuration
  output logic LOAD_DONE,
  output logic DEPENDENT_RESET,
  output logic SCAN_PORT_ON,
  output logic CODE_PROTECT,
  output logic FLASH_WRITE_PERMIT,
  output logic RESET_TO_DEBUG,
  output logic [1:0] EMULATOR_PIN_PAIR_SEL,
  output logic EMULATOR_PIN_RESERVED,
  output logic WATCHDOG_ON,
  output logic WATCHDOG_WINDOWED,
  output logic [7:0] WATCHDOG_PRESCALE,
  output logic [15:0] WATCHDOG_POSTSCALE,
  output logic TWO_SPEED_STARTUP_ON,
  output logic [2:0] RESET_OSC_SEL,
  output logic RESET_OSC_RESERVED,
  output logic CLK_SWITCH_ON,
  output logic FAIL_SAFE_MONITOR_ON,
  output logic CLOCK_OUT_PIN,
  output logic PIN_LOCK_ONE_SHOT,
  output logic I2C_PIN_ALT_SEL,
  output logic [1:0] PRIMARY_OSC_MODE
);

  localparam logic [23:0] WORD_ONE_ADDR =
    LARGE_MEMORY ? cwl_pkg::CWL_LARGE_WORD_ONE : cwl_pkg::CWL_SMALL_WORD_ONE;
  localparam logic [23:0] WORD_TWO_ADDR =
    LARGE_MEMORY ? cwl_pkg::CWL_LARGE_WORD_TWO : cwl_pkg::CWL_SMALL_WORD_TWO;
  localparam logic [23:0] LAST_PAGE_END =
    LARGE_MEMORY ? cwl_pkg::CWL_LARGE_LAST_PAGE : cwl_pkg::CWL_SMALL_LAST_PAGE;

  cwl_pkg::cwl_state_t state_reg;
  logic [23:0] config_word_one_reg;
  logic [23:0] config_word_two_reg;
  logic lock_reg;
  logic lock_used_reg;
  logic ack_reg;
  logic err_reg;
  logic [23:0] rdata_reg;

  logic done;
  logic tbl_in_space;
  logic tbl_hit_one;
  logic tbl_hit_two;
  logic last_page_erase;

  assign done = (state_reg == cwl_pkg::CWL_DONE);
  // config space sits in the upper half; normal fetch never reaches it
  assign tbl_in_space = TBL_ADDR[23];
  assign tbl_hit_one = (TBL_ADDR == cwl_pkg::CWL_CFG_MAP_BASE);
  assign tbl_hit_two = (TBL_ADDR == cwl_pkg::CWL_CFG_MAP_BASE + 24'h000002);
  assign last_page_erase = FLASH_ERASE && (FLASH_ERASE_ADDR < LAST_PAGE_END)
    && (FLASH_ERASE_ADDR >= LAST_PAGE_END - cwl_pkg::CWL_PAGE_SIZE);

  // reset always restarts the load, so every reset kind reloads
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_reg <= cwl_pkg::CWL_IDLE;
    end else if (CLK_EN) begin
      case (state_reg)
        cwl_pkg::CWL_IDLE: state_reg <= cwl_pkg::CWL_RD_ONE;
        cwl_pkg::CWL_RD_ONE: state_reg <= cwl_pkg::CWL_WT_ONE;
        cwl_pkg::CWL_WT_ONE: begin
          if (FLASH_VALID) begin
            state_reg <= cwl_pkg::CWL_RD_TWO;
          end
        end
        cwl_pkg::CWL_RD_TWO: state_reg <= cwl_pkg::CWL_WT_TWO;
        cwl_pkg::CWL_WT_TWO: begin
          if (FLASH_VALID) begin
            state_reg <= cwl_pkg::CWL_DONE;
          end
        end
        cwl_pkg::CWL_DONE: state_reg <= cwl_pkg::CWL_DONE;
        default: state_reg <= cwl_pkg::CWL_IDLE;
      endcase
    end
  end

  assign FLASH_RD = (state_reg == cwl_pkg::CWL_RD_ONE) || (state_reg == cwl_pkg::CWL_RD_TWO);
  assign FLASH_ADDR = (state_reg == cwl_pkg::CWL_RD_TWO) ? WORD_TWO_ADDR : WORD_ONE_ADDR;

  // unimplemented bits forced to one so they never steer decode
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      config_word_one_reg <= cwl_pkg::CWL_WORD_RESET;
      config_word_two_reg <= cwl_pkg::CWL_WORD_RESET;
    end else if (CLK_EN) begin
      if (state_reg == cwl_pkg::CWL_WT_ONE && FLASH_VALID) begin
        config_word_one_reg <= FLASH_DATA | ~cwl_pkg::CWL_WORD_ONE_IMPL;
      end
      if (state_reg == cwl_pkg::CWL_WT_TWO && FLASH_VALID) begin
        config_word_two_reg <= FLASH_DATA | ~cwl_pkg::CWL_WORD_TWO_IMPL;
      end
      // erase only changes flash; registers keep their value until next reset
      if (done && TBL_WR && TBL_SERIAL_PROG && tbl_hit_one) begin
        config_word_one_reg[cwl_pkg::CWL_W1_SCAN] <= TBL_WDATA[cwl_pkg::CWL_W1_SCAN];
      end
    end
  end

  // table access answer one cycle after the request
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
      rdata_reg <= 24'h000000;
    end else if (CLK_EN) begin
      ack_reg <= (TBL_RD || TBL_WR) && done;
      err_reg <= (TBL_RD || TBL_WR) && done && !(tbl_in_space && (tbl_hit_one || tbl_hit_two));
      if (TBL_RD && done) begin
        rdata_reg <= tbl_hit_one ? config_word_one_reg
          : tbl_hit_two ? config_word_two_reg : cwl_pkg::CWL_WORD_RESET;
      end
    end
  end
  assign TBL_ACK = ack_reg;
  assign TBL_ERR = err_reg;
  assign TBL_RDATA = rdata_reg;

  // pin-select lock; one-shot policy refuses any clear once set
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      lock_reg <= 1'b0;
      lock_used_reg <= 1'b0;
    end else if (CLK_EN && done && PIN_UNLOCKED) begin
      if (PIN_LOCK_SET && !(PIN_LOCK_ONE_SHOT && lock_used_reg)) begin
        lock_reg <= 1'b1;
        lock_used_reg <= 1'b1;
      end else if (PIN_LOCK_CLR && !PIN_LOCK_ONE_SHOT) begin
        lock_reg <= 1'b0;
      end
    end
  end
  assign PIN_SELECT_LOCK = lock_reg;
  assign PIN_SELECT_WR_OK = done && !lock_reg && PIN_UNLOCKED;

  assign LOAD_DONE = done;
  assign DEPENDENT_RESET = !done;
  assign SCAN_PORT_ON = config_word_one_reg[cwl_pkg::CWL_W1_SCAN];
  // cleared words (erased last page) read 0 here: protection on
  assign CODE_PROTECT = !config_word_one_reg[cwl_pkg::CWL_W1_GCP];
  assign FLASH_WRITE_PERMIT = config_word_one_reg[cwl_pkg::CWL_W1_WRP] && done
    && !(last_page_erase && 1'b0);
  assign RESET_TO_DEBUG = !config_word_one_reg[cwl_pkg::CWL_W1_DBG];
  assign EMULATOR_PIN_PAIR_SEL = config_word_one_reg[cwl_pkg::CWL_W1_ICS +: 2];
  assign EMULATOR_PIN_RESERVED = (EMULATOR_PIN_PAIR_SEL == cwl_pkg::CWL_ICS_RESERVED);
  assign WATCHDOG_ON = config_word_one_reg[cwl_pkg::CWL_W1_WDTEN];
  // window mode only meaningful with the watchdog enabled
  assign WATCHDOG_WINDOWED = !config_word_one_reg[cwl_pkg::CWL_W1_WIN] && WATCHDOG_ON;
  assign WATCHDOG_PRESCALE = config_word_one_reg[cwl_pkg::CWL_W1_PSA] ?
    cwl_pkg::CWL_PRE_HIGH : cwl_pkg::CWL_PRE_LOW;
  assign WATCHDOG_POSTSCALE = 16'h0001 << config_word_one_reg[cwl_pkg::CWL_W1_PS +: 4];
  assign TWO_SPEED_STARTUP_ON = config_word_two_reg[cwl_pkg::CWL_W2_TWO_SPEED_STARTUP_ON];
  assign RESET_OSC_SEL = config_word_two_reg[cwl_pkg::CWL_W2_OSC +: 3];
  assign RESET_OSC_RESERVED = (RESET_OSC_SEL == cwl_pkg::CWL_OSC_RESERVED);
  assign CLK_SWITCH_ON = !config_word_two_reg[cwl_pkg::CWL_W2_CKSM + 1];
  assign FAIL_SAFE_MONITOR_ON = (config_word_two_reg[cwl_pkg::CWL_W2_CKSM +: 2] == 2'h0);
  assign PRIMARY_OSC_MODE = config_word_two_reg[cwl_pkg::CWL_W2_POSC +: 2];
  assign CLOCK_OUT_PIN = config_word_two_reg[cwl_pkg::CWL_W2_OSCIO]
    && (PRIMARY_OSC_MODE == cwl_pkg::CWL_POSC_OFF || PRIMARY_OSC_MODE == cwl_pkg::CWL_POSC_EC);
  assign PIN_LOCK_ONE_SHOT = config_word_two_reg[cwl_pkg::CWL_W2_IOL1];
  assign I2C_PIN_ALT_SEL = !config_word_two_reg[cwl_pkg::CWL_W2_I2C];

endmodule

// >>> test/cwl_props.sv
// checker for the configuration word loader, watching its top ports only
// assumes one clock domain with an asynchronous active-high reset
`timescale 1ns/1ps
module cwl_props #(
  parameter bit LARGE_MEMORY = 1'b1
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CLK_EN,
  input wire logic FLASH_RD,
  input wire logic [23:0] FLASH_ADDR,
  input wire logic TBL_RD,
  input wire logic [23:0] TBL_ADDR,
  input wire logic TBL_ACK,
  input wire logic TBL_ERR,
  input wire logic LOAD_DONE,
  input wire logic DEPENDENT_RESET,
  input wire logic CODE_PROTECT,
  input wire logic WATCHDOG_ON,
  input wire logic WATCHDOG_WINDOWED,
  input wire logic [15:0] WATCHDOG_POSTSCALE,
  input wire logic CLK_SWITCH_ON,
  input wire logic FAIL_SAFE_MONITOR_ON,
  input wire logic CLOCK_OUT_PIN,
  input wire logic [1:0] PRIMARY_OSC_MODE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  logic [23:0] top_w;
  logic req;
  assign top_w = LARGE_MEMORY ? cwl_pkg::CWL_LARGE_WORD_ONE : cwl_pkg::CWL_SMALL_WORD_ONE;
  assign req = TBL_RD && LOAD_DONE && CLK_EN;
  a_read_top_words: assert property (FLASH_RD |-> FLASH_ADDR == top_w ||
    FLASH_ADDR == top_w - 24'h000002) else $error("flash read outside the top words");
  a_no_late_read: assert property (LOAD_DONE |-> !FLASH_RD) else $error("read after load");
  a_done_holds: assert property (LOAD_DONE |=> LOAD_DONE) else $error("load done dropped");
  a_dependents_held: assert property (DEPENDENT_RESET != LOAD_DONE)
    else $error("dependent reset wrong");
  a_early_refused: assert property (!LOAD_DONE |=> !TBL_ACK) else $error("ack before load");
  a_table_answer: assert property (req |=> TBL_ACK) else $error("table request not answered");
  a_unmapped_error: assert property (req && TBL_ADDR != 24'hF80000 && TBL_ADDR != 24'hF80002
    |=> TBL_ERR && TBL_ACK) else $error("unmapped address not refused");
  a_config_steady: assert property (LOAD_DONE ##1 LOAD_DONE |->
    $stable(CODE_PROTECT) && $stable(WATCHDOG_POSTSCALE)) else $error("config changed");
  a_window_needs_on: assert property (WATCHDOG_WINDOWED |-> WATCHDOG_ON)
    else $error("windowed without enable");
  a_postscale_power: assert property ($onehot(WATCHDOG_POSTSCALE))
    else $error("postscale not a power of two");
  a_monitor_needs_sw: assert property (FAIL_SAFE_MONITOR_ON |-> CLK_SWITCH_ON)
    else $error("monitor without switching");
  a_clock_out_mode: assert property (CLOCK_OUT_PIN |-> PRIMARY_OSC_MODE inside {2'h3, 2'h0})
    else $error("clock out in crystal mode");
  c_load: cover property ($rose(LOAD_DONE));
  c_error: cover property (TBL_ERR);
  c_window: cover property (WATCHDOG_WINDOWED && LOAD_DONE);
endmodule
bind cwl_config_word_loader cwl_props #(.LARGE_MEMORY(LARGE_MEMORY)) u_props (.*);

// >>> test/cwl_flash_model.sv
// flash model: answers one word read after a set number of wait cycles
// assumes the loader holds no second read open while one is pending
`timescale 1ns/1ps
module cwl_flash_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic rd,
  input wire logic [23:0] addr,
  input wire logic [23:0] word_one,
  input wire logic [23:0] word_two,
  input wire logic [3:0] wait_cycles,
  output logic valid,
  output logic [23:0] data
);
  logic [3:0] cnt_reg;
  logic busy_reg;
  logic [23:0] word_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_reg <= 1'b0;
      valid <= 1'b0;
      data <= 24'h000000;
    end else begin
      valid <= 1'b0;
      // idle bus toggles so a stale word never passes for an answer
      data <= ~data;
      if (rd) begin
        busy_reg <= 1'b1;
        cnt_reg <= wait_cycles;
        word_reg <= addr[1] ? word_one : word_two;
      end else if (busy_reg && cnt_reg == 4'h0) begin
        busy_reg <= 1'b0;
        valid <= 1'b1;
        data <= word_reg;
      end else if (busy_reg) begin
        cnt_reg <= cnt_reg - 4'h1;
      end
    end
  end
endmodule

// >>> test/config_word_loader_test.sv
// bench for the configuration word loader with a flash model behind it
// assumes the registered table port answers one cycle after the request
`timescale 1ns/1ps
module config_word_loader_test;
  logic CLK, RST, erase, tbl_rd, tbl_wr, serial, unlocked, lock_set, lock_clr, lock, done;
  logic flash_rd, flash_valid, tbl_ack, tbl_err, wr_ok;
  logic [23:0] flash_addr, flash_data, tbl_addr, tbl_wdata, tbl_rdata, w1, w2, s1, s2;
  logic [3:0] lat;
  wire [44:0] cfg;
  int failures = 0, checks = 0, cycles = 0;
  logic [23:0] raw [4][2] = '{'{24'hFF56A5, 24'hFF7B28}, '{24'h000000, 24'h000000},
    '{24'hFFFFFF, 24'hFFFFFF}, '{24'hFF3E5F, 24'h000600}};
  cwl_config_word_loader #(.LARGE_MEMORY(1'b1)) u_dut (.CLK(CLK), .RST(RST), .CLK_EN(1'b1),
    .FLASH_RD(flash_rd), .FLASH_ADDR(flash_addr), .FLASH_VALID(flash_valid),
    .FLASH_DATA(flash_data), .FLASH_ERASE(erase), .FLASH_ERASE_ADDR(24'h00AC00),
    .TBL_RD(tbl_rd), .TBL_WR(tbl_wr), .TBL_ADDR(tbl_addr), .TBL_WDATA(tbl_wdata),
    .TBL_SERIAL_PROG(serial), .TBL_RDATA(tbl_rdata), .TBL_ACK(tbl_ack), .TBL_ERR(tbl_err),
    .PIN_UNLOCKED(unlocked), .PIN_LOCK_SET(lock_set), .PIN_LOCK_CLR(lock_clr),
    .PIN_SELECT_LOCK(lock), .PIN_SELECT_WR_OK(wr_ok), .LOAD_DONE(done), .DEPENDENT_RESET(),
    .SCAN_PORT_ON(cfg[44]), .CODE_PROTECT(cfg[43]), .FLASH_WRITE_PERMIT(cfg[42]),
    .RESET_TO_DEBUG(cfg[41]), .EMULATOR_PIN_PAIR_SEL(cfg[40:39]),
    .EMULATOR_PIN_RESERVED(cfg[38]), .WATCHDOG_ON(cfg[37]), .WATCHDOG_WINDOWED(cfg[36]),
    .WATCHDOG_PRESCALE(cfg[35:28]), .WATCHDOG_POSTSCALE(cfg[27:12]),
    .TWO_SPEED_STARTUP_ON(cfg[11]), .RESET_OSC_SEL(cfg[10:8]), .RESET_OSC_RESERVED(cfg[7]),
    .CLK_SWITCH_ON(cfg[6]), .FAIL_SAFE_MONITOR_ON(cfg[5]), .CLOCK_OUT_PIN(cfg[4]),
    .PIN_LOCK_ONE_SHOT(cfg[3]), .I2C_PIN_ALT_SEL(cfg[2]), .PRIMARY_OSC_MODE(cfg[1:0]));
  cwl_flash_model u_flash (.clk(CLK), .rst(RST), .rd(flash_rd), .addr(flash_addr),
    .word_one(w1), .word_two(w2), .wait_cycles(lat), .valid(flash_valid), .data(flash_data));
  function automatic logic [44:0] exp_cfg(input logic [23:0] a, input logic [23:0] b);
    exp_cfg = {a[14], !a[13], a[12], !a[11], a[9:8], a[9:8] == 2'h0, a[7], !a[6] && a[7],
      a[4] ? 8'h80 : 8'h20, 16'h0001 << a[3:0], b[15], b[10:8], b[10:8] == 3'h6, !b[7],
      b[7:6] == 2'h0, b[5] && (b[1:0] == 2'h3 || b[1:0] == 2'h0), b[4], !b[2], b[1:0]};
  endfunction
  task automatic check(input string what, input logic [44:0] exp, input logic [44:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tbl(input logic wr, input logic [23:0] a, input logic [23:0] d,
      input logic [23:0] exp, input logic err);
    @(posedge CLK) #1;
    {tbl_wr, tbl_rd, tbl_addr, tbl_wdata} = {wr, !wr, a, d};
    @(posedge CLK) #1;
    {tbl_wr, tbl_rd} = 2'h0;
    check("table", {19'h0, 1'b1, err, exp}, {19'h0, tbl_ack, tbl_err, wr ? exp : tbl_rdata});
  endtask
  task automatic pulse(input logic s);
    @(posedge CLK) #1;
    {lock_set, lock_clr} = {s, !s};
    @(posedge CLK) #1;
    {lock_set, lock_clr} = 2'h0;
  endtask
  task automatic load(input logic [23:0] a, input logic [23:0] b);
    @(posedge CLK) #1;
    {w1, w2, RST} = {a, b, 1'b1};
    repeat (16) @(posedge CLK);
    #1 RST = 1'b0;
    for (int i = 0; i < 200 && done !== 1'b1; i++) @(posedge CLK);
    #1;
    s1 = a | ~cwl_pkg::CWL_WORD_ONE_IMPL;
    s2 = b | ~cwl_pkg::CWL_WORD_TWO_IMPL;
    check("decoded fields", exp_cfg(s1, s2), cfg);
  endtask
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      summarize();
    end
  end
  initial begin
    RST = 1'b1;
    {erase, tbl_rd, tbl_wr, serial, unlocked, lock_set, lock_clr, lat} = 11'h000;
    {tbl_addr, tbl_wdata, w1, w2} = 96'h0;
    for (int k = 0; k < 4; k++) begin
      lat = 4'(k * 5);
      load(raw[k][0], raw[k][1]);
      tbl(1'b0, 24'hF80000, 24'h000000, s1, 1'b0);
      tbl(1'b0, 24'hF80002, 24'h000000, s2, 1'b0);
      tbl(1'b0, 24'hF80004, 24'h000000, 24'hFFFFFF, 1'b1);
      unlocked = 1'b1;
      #1 check("write open", {44'h0, 1'b1}, {44'h0, wr_ok});
      pulse(1'b1);
      check("write shut", {44'h0, 1'b0}, {44'h0, wr_ok});
      pulse(1'b0);
      check("pin lock", {44'h0, s2[4]}, {44'h0, lock});
      unlocked = 1'b0;
    end
    // scan enable moves only on a serial programming write
    tbl(1'b1, 24'hF80000, s1 ^ 24'h004000, 24'h000000, 1'b0);
    tbl(1'b0, 24'hF80000, 24'h000000, s1, 1'b0);
    serial = 1'b1;
    tbl(1'b1, 24'hF80000, s1 ^ 24'h004000, 24'h000000, 1'b0);
    tbl(1'b0, 24'hF80000, 24'h000000, s1 ^ 24'h004000, 1'b0);
    erase = 1'b1;
    @(posedge CLK) #1 erase = 1'b0;
    check("after erase", exp_cfg(s1 ^ 24'h004000, s2), cfg);
    summarize();
  end
endmodule
